//--- pkg/byte_op_consts.vh
// Opcode fields, operation codes and flag masks for the instruction decoder
`ifndef BYTE_OP_CONSTS_VH
`define BYTE_OP_CONSTS_VH

// Word layout
`define W_OPC_HI        15
`define W_DEST_BIT      9
`define W_ACC_BIT       8
`define W_LONG_PREFIX   4'hF
`define W_MOVE_NIB      4'hC
`define W_BRA_NIB       4'hD
`define W_CTRL_NIB      4'hE

// Operation codes sent to the ALU
`define OP_NONE         5'h00
`define OP_ADD          5'h01
`define OP_ADDC         5'h02
`define OP_AND          5'h03
`define OP_OR           5'h04
`define OP_XOR          5'h05
`define OP_COM          5'h06
`define OP_SUB_RA       5'h07
`define OP_SUBB_RA      5'h08
`define OP_SUBB_AR      5'h09
`define OP_DEC          5'h0A
`define OP_INC          5'h0B
`define OP_DEC_SZ       5'h0C
`define OP_DEC_SNZ      5'h0D
`define OP_INC_SZ       5'h0E
`define OP_INC_SNZ      5'h0F
`define OP_CMP_EQ       5'h10
`define OP_CMP_GT       5'h11
`define OP_CMP_LT       5'h12
`define OP_TEST_Z       5'h13
`define OP_RLC          5'h14
`define OP_RRC          5'h15
`define OP_RL           5'h16
`define OP_RR           5'h17
`define OP_MUL          5'h18
`define OP_CLR          5'h19
`define OP_SET          5'h1A
`define OP_STORE        5'h1B
`define OP_NEG          5'h1C
`define OP_MOVF         5'h1D
`define OP_SWAP         5'h1E
`define OP_BIT          5'h1F

// Flag enable masks, bit order C, DC, Z, OV, N from bit 0
`define FM_NONE         5'h00
`define FM_ALL          5'h1F
`define FM_ZN           5'h14
`define FM_CZN          5'h15
`define FM_Z            5'h04

`endif

//--- verilog/operand_fields.v
// Operand field extraction from one instruction word
`timescale 1ns/1ps
`include "byte_op_consts.vh"

module operand_fields (
	// Word from fetch
	input  wire [15:0] word,
	// Fields
	output wire [7:0]  file_addr,
	output wire        dest_bit,
	output wire        acc_bit,
	output wire [2:0]  bit_sel,
	output wire [7:0]  literal,
	output wire [11:0] addr12,
	output wire [19:0] bra_off,
	output wire [19:0] cbr_off
);

	// Fields packed below the opcode, msb first
	assign file_addr = word[7:0];
	assign dest_bit  = word[`W_DEST_BIT];
	assign acc_bit   = word[`W_ACC_BIT];
	assign bit_sel   = word[11:9];
	assign literal   = word[7:0];
	assign addr12    = word[11:0];
	// Offsets sign-extended so the datapath adds them to the full counter
	assign bra_off   = {{9{word[10]}}, word[10:0]};
	assign cbr_off   = {{12{word[7]}}, word[7:0]};

endmodule

//--- verilog/bank_resolve.v
// Bank resolution of an 8-bit file address into a 12-bit register address
`timescale 1ns/1ps

module bank_resolve #(
	parameter [7:0] ACCESS_SPLIT = 8'h80
)(
	// Inputs
	input  wire [7:0]  file_addr,
	input  wire        acc_bit,
	input  wire [3:0]  bank_select_pointer,
	// Result
	output wire [11:0] reg_addr
);

	// Fixed access bank: low part in bank 0, high part in the top bank
	wire [11:0] access_addr;
	assign access_addr = (file_addr < ACCESS_SPLIT) ? {4'h0, file_addr} : {4'hF, file_addr};
	assign reg_addr    = acc_bit ? {bank_select_pointer, file_addr} : access_addr;

endmodule

//--- verilog/byte_op_instruction_decoder.v
// Instruction decoder for byte-oriented and general operand formats
`timescale 1ns/1ps
`include "byte_op_consts.vh"

module byte_op_instruction_decoder #(
	parameter [11:0] PORT_FIRST      = 12'hF80,
	parameter [11:0] PORT_LAST       = 12'hF84,
	parameter [11:0] TIMER_ZERO_ADDR = 12'hFD6,
	parameter [7:0]  ACCESS_SPLIT    = 8'h80
)(
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// Fetch stage
	input  wire [15:0] instr_word,
	input  wire        instr_valid,
	// Datapath feedback
	input  wire [3:0]  bank_select_pointer,
	input  wire        cond_true,
	// Decoded controls
	output reg         dec_valid,
	output reg         nop_slot,
	output reg  [4:0]  alu_op,
	output reg  [4:0]  flag_we,
	output reg         dest_acc,
	output reg         dest_reg,
	output reg  [11:0] reg_addr,
	output reg  [2:0]  bit_sel,
	output reg  [7:0]  literal,
	output reg         is_skip,
	output reg  [1:0]  exec_cycles,
	output reg         prod_we,
	output reg         src_from_pins,
	output reg         prescale_clr,
	// Two-word results
	output reg         move_valid,
	output reg  [11:0] move_src,
	output reg  [11:0] move_dst,
	output reg         jump_valid,
	output reg  [19:0] jump_target,
	output reg         is_call,
	output reg         fast_save,
	// Relative branches
	output reg         rel_valid,
	output reg         rel_is_cond,
	output reg  [2:0]  rel_cond_code,
	output reg  [19:0] rel_offset
);

	localparam [1:0] ST_FIRST  = 2'b01;
	localparam [1:0] ST_SECOND = 2'b10;
	localparam [1:0] K_MOVE = 2'h0;
	localparam [1:0] K_GOTO = 2'h1;
	localparam [1:0] K_CALL = 2'h2;
	localparam [1:0] K_OTHER = 2'h3;

	// Fields of the incoming word
	wire [7:0]  f_addr;
	wire        f_d;
	wire        f_a;
	wire [2:0]  f_bit;
	wire [7:0]  f_lit;
	wire [11:0] f_addr12;
	wire [19:0] f_bra;
	wire [19:0] f_cbr;
	wire [11:0] f_reg_addr;

	operand_fields u_fields (
		.word      (instr_word),
		.file_addr (f_addr),
		.dest_bit  (f_d),
		.acc_bit   (f_a),
		.bit_sel   (f_bit),
		.literal   (f_lit),
		.addr12    (f_addr12),
		.bra_off   (f_bra),
		.cbr_off   (f_cbr)
	);

	bank_resolve #(
		.ACCESS_SPLIT (ACCESS_SPLIT)
	) u_bank (
		.file_addr           (f_addr),
		.acc_bit             (f_a),
		.bank_select_pointer (bank_select_pointer),
		.reg_addr            (f_reg_addr)
	);

	// State
	reg [1:0]  state_r;
	reg [1:0]  state_nxt;
	reg [1:0]  hold_kind_r;
	reg [11:0] hold_low_r;
	reg        hold_fast_r;
	reg        hold_kill_r;
	reg        squash_r;
	reg        squash_nxt;

	// Byte-operation table
	reg [4:0] b_op;
	reg [4:0] b_fm;
	reg       b_has_d;
	reg       b_always_reg;
	reg       b_skip;
	reg       b_valid;

	// Byte operations keyed on the top six bits; d/a forms share one entry
	always @* begin
		b_op         = `OP_NONE;
		b_fm         = `FM_NONE;
		b_has_d      = 1'b1;
		b_always_reg = 1'b0;
		b_skip       = 1'b0;
		b_valid      = 1'b1;
		case (instr_word[15:10])
			6'b001001: begin b_op = `OP_ADD;     b_fm = `FM_ALL; end
			6'b001000: begin b_op = `OP_ADDC;    b_fm = `FM_ALL; end
			6'b000101: begin b_op = `OP_AND;     b_fm = `FM_ZN;  end
			6'b000100: begin b_op = `OP_OR;      b_fm = `FM_ZN;  end
			6'b000110: begin b_op = `OP_XOR;     b_fm = `FM_ZN;  end
			6'b000111: begin b_op = `OP_COM;     b_fm = `FM_ZN;  end
			6'b010111: begin b_op = `OP_SUB_RA;  b_fm = `FM_ALL; end
			6'b010110: begin b_op = `OP_SUBB_RA; b_fm = `FM_ALL; end
			6'b010101: begin b_op = `OP_SUBB_AR; b_fm = `FM_ALL; end
			6'b000001: begin b_op = `OP_DEC;     b_fm = `FM_ALL; end
			6'b001010: begin b_op = `OP_INC;     b_fm = `FM_ALL; end
			6'b001011: begin b_op = `OP_DEC_SZ;  b_skip = 1'b1; end
			6'b010011: begin b_op = `OP_DEC_SNZ; b_skip = 1'b1; end
			6'b001111: begin b_op = `OP_INC_SZ;  b_skip = 1'b1; end
			6'b010010: begin b_op = `OP_INC_SNZ; b_skip = 1'b1; end
			6'b001101: begin b_op = `OP_RLC;     b_fm = `FM_CZN; end
			6'b001100: begin b_op = `OP_RRC;     b_fm = `FM_CZN; end
			6'b010001: begin b_op = `OP_RL;      b_fm = `FM_ZN;  end
			6'b010000: begin b_op = `OP_RR;      b_fm = `FM_ZN;  end
			6'b010100: begin b_op = `OP_MOVF;    b_fm = `FM_ZN;  end
			6'b001110: b_op = `OP_SWAP;
			6'b000000: begin
				b_has_d = 1'b0;
				if (instr_word[9]) begin
					b_op = `OP_MUL;
				end else begin
					b_valid = 1'b0;
				end
			end
			6'b011000, 6'b011001, 6'b011010, 6'b011011: begin
				b_has_d = 1'b0;
				case (instr_word[11:9])
					3'b000: begin b_op = `OP_CMP_LT; b_skip = 1'b1; end
					3'b001: begin b_op = `OP_CMP_EQ; b_skip = 1'b1; end
					3'b010: begin b_op = `OP_CMP_GT; b_skip = 1'b1; end
					3'b011: begin b_op = `OP_TEST_Z; b_skip = 1'b1; end
					3'b100: begin b_op = `OP_SET;   b_always_reg = 1'b1; end
					3'b101: begin
						b_op         = `OP_CLR;
						b_fm         = `FM_Z;
						b_always_reg = 1'b1;
					end
					3'b110: begin
						b_op         = `OP_NEG;
						b_fm         = `FM_ALL;
						b_always_reg = 1'b1;
					end
					default: begin b_op = `OP_STORE; b_always_reg = 1'b1; end
				endcase
			end
			default: b_valid = 1'b0;
		endcase
	end

	// Word classes outside the byte table
	wire nib_long  = (instr_word[15:12] == `W_LONG_PREFIX);
	wire is_move   = (instr_word[15:12] == `W_MOVE_NIB);
	wire is_goto   = (instr_word[15:8] == 8'hEF);
	wire is_callw  = (instr_word[15:9] == 7'b1110110);
	wire is_other2 = (instr_word[15:8] == 8'hEE);
	wire is_bra    = (instr_word[15:12] == `W_BRA_NIB);
	wire is_cbr    = (instr_word[15:11] == 5'b11100);
	wire is_bitop  = (instr_word[15:12] == 4'h7) || (instr_word[15:14] == 2'b10);
	wire is_bitwr  = (instr_word[15:12] == 4'h7) || (instr_word[15:13] == 3'b100);
	wire two_word  = is_move | is_goto | is_callw | is_other2;
	// A test that turned out true also squashes a word not yet fetched
	wire kill_now  = squash_r | cond_true;

	// Which byte operations write back into the addressed register
	wire wr_reg    = b_valid & (b_always_reg | (b_has_d & f_d));
	wire reads_reg = b_valid & (b_op != `OP_CLR) & (b_op != `OP_SET) & (b_op != `OP_STORE);
	wire in_ports  = (f_reg_addr >= PORT_FIRST) && (f_reg_addr <= PORT_LAST);
	// Compare-less, multiply and test are marked even though they do not write
	wire marked    = wr_reg | is_bitwr | (b_op == `OP_CMP_LT) | (b_op == `OP_MUL)
	                 | (b_op == `OP_TEST_Z);

	// Next-state logic
	always @* begin
		state_nxt  = state_r;
		squash_nxt = squash_r | cond_true;
		if (instr_valid) begin
			squash_nxt = 1'b0;
			case (state_r)
				ST_FIRST: begin
					if (two_word) begin
						state_nxt = ST_SECOND;
					end
					// Unconditional relative jumps lose the following slot
					if (!kill_now && is_bra) begin
						squash_nxt = 1'b1;
					end
				end
				ST_SECOND: state_nxt = ST_FIRST;
				default:   state_nxt = ST_FIRST;
			endcase
		end
	end

	// Held first word of a two-word instruction
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r     <= ST_FIRST;
			squash_r    <= 1'b0;
			hold_kind_r <= K_OTHER;
			hold_low_r  <= 12'h000;
			hold_fast_r <= 1'b0;
			hold_kill_r <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			squash_r <= squash_nxt;
			if (instr_valid && state_r == ST_FIRST && two_word) begin
				hold_kind_r <= is_move ? K_MOVE : is_goto ? K_GOTO : is_callw ? K_CALL : K_OTHER;
				hold_low_r  <= f_addr12;
				hold_fast_r <= instr_word[8];
				// A skipped two-word instruction also idles its second word
				hold_kill_r <= kill_now;
			end
		end
	end

	// Registered decoded controls
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			dec_valid     <= 1'b0;
			nop_slot      <= 1'b0;
			alu_op        <= `OP_NONE;
			flag_we       <= `FM_NONE;
			dest_acc      <= 1'b0;
			dest_reg      <= 1'b0;
			reg_addr      <= 12'h000;
			bit_sel       <= 3'h0;
			literal       <= 8'h00;
			is_skip       <= 1'b0;
			exec_cycles   <= 2'h0;
			prod_we       <= 1'b0;
			src_from_pins <= 1'b0;
			prescale_clr  <= 1'b0;
			move_valid    <= 1'b0;
			move_src      <= 12'h000;
			move_dst      <= 12'h000;
			jump_valid    <= 1'b0;
			jump_target   <= 20'h00000;
			is_call       <= 1'b0;
			fast_save     <= 1'b0;
			rel_valid     <= 1'b0;
			rel_is_cond   <= 1'b0;
			rel_cond_code <= 3'h0;
			rel_offset    <= 20'h00000;
		end else begin
			// Pulses default low; fields hold until the next word
			dec_valid     <= instr_valid;
			nop_slot      <= 1'b0;
			alu_op        <= `OP_NONE;
			flag_we       <= `FM_NONE;
			dest_acc      <= 1'b0;
			dest_reg      <= 1'b0;
			is_skip       <= 1'b0;
			prod_we       <= 1'b0;
			src_from_pins <= 1'b0;
			prescale_clr  <= 1'b0;
			move_valid    <= 1'b0;
			jump_valid    <= 1'b0;
			rel_valid     <= 1'b0;
			if (instr_valid) begin
				reg_addr    <= f_reg_addr;
				bit_sel     <= f_bit;
				literal     <= f_lit;
				exec_cycles <= 2'h1;
				if (state_r == ST_SECOND) begin
					if (hold_kill_r) begin
						nop_slot <= 1'b1;
					end else if (hold_kind_r == K_MOVE) begin
						move_valid <= 1'b1;
						move_src   <= hold_low_r;
						move_dst   <= f_addr12;
					end else if (hold_kind_r != K_OTHER) begin
						jump_valid  <= 1'b1;
						jump_target <= {f_addr12, hold_low_r[7:0]};
						is_call     <= (hold_kind_r == K_CALL);
						fast_save   <= (hold_kind_r == K_CALL) & hold_fast_r;
					end
				end else if (kill_now || nib_long) begin
					// Squashed slot or stray second word runs as no-op
					nop_slot <= 1'b1;
				end else if (two_word) begin
					exec_cycles <= 2'h2;
				end else if (is_bra) begin
					rel_valid     <= 1'b1;
					rel_is_cond   <= 1'b0;
					rel_cond_code <= instr_word[10:8];
					rel_offset    <= f_bra;
					is_call       <= instr_word[11];
					fast_save     <= 1'b0;
					exec_cycles   <= 2'h2;
				end else if (is_cbr) begin
					rel_valid     <= 1'b1;
					rel_is_cond   <= 1'b1;
					rel_cond_code <= instr_word[10:8];
					rel_offset    <= f_cbr;
				end else if (b_valid) begin
					alu_op        <= b_op;
					flag_we       <= b_fm;
					dest_reg      <= wr_reg;
					dest_acc      <= b_has_d & ~f_d;
					is_skip       <= b_skip;
					prod_we       <= (b_op == `OP_MUL);
					src_from_pins <= wr_reg & reads_reg & in_ports;
					prescale_clr  <= marked & (f_reg_addr == TIMER_ZERO_ADDR);
				end else if (is_bitop) begin
					alu_op        <= `OP_BIT;
					is_skip       <= ~is_bitwr;
					dest_reg      <= is_bitwr;
					src_from_pins <= is_bitwr & in_ports;
					prescale_clr  <= is_bitwr & (f_reg_addr == TIMER_ZERO_ADDR);
				end
			end
		end
	end

endmodule

//--- verif/skip_datapath_model.sv
// Datapath stand-in that answers skips and conditional branches
`timescale 1ns/1ps

module skip_datapath_model (
	// Decoded controls
	input  wire logic is_skip,
	input  wire logic rel_valid,
	input  wire logic rel_is_cond,
	// Bench knob: outcome of the test
	input  wire logic take,
	// Answer to the decoder
	output logic      cond_true
);
	// Level answer in the cycle the skip shows, so the following slot is squashed
	assign cond_true = take & (is_skip | (rel_valid & rel_is_cond));
endmodule

//--- verif/byte_op_decoder_checker.sv
// Port-level assertions for the instruction decoder
`timescale 1ns/1ps
`include "byte_op_consts.vh"

module byte_op_decoder_checker #(
	parameter [11:0] PORT_FIRST      = 12'hF80,
	parameter [11:0] PORT_LAST       = 12'hF84,
	parameter [11:0] TIMER_ZERO_ADDR = 12'hFD6
)(
	// Clock, reset and fetch side
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic [15:0] instr_word,
	input wire logic        instr_valid,
	input wire logic        cond_true,
	// Decoded controls
	input wire logic        dec_valid,
	input wire logic        nop_slot,
	input wire logic [4:0]  alu_op,
	input wire logic [4:0]  flag_we,
	input wire logic        dest_acc,
	input wire logic        dest_reg,
	input wire logic [11:0] reg_addr,
	input wire logic        is_skip,
	input wire logic        prod_we,
	input wire logic        src_from_pins,
	input wire logic        prescale_clr,
	input wire logic        move_valid,
	input wire logic        rel_valid,
	input wire logic        rel_is_cond
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// A slot that executes, and a squashed slot that must do nothing
	sequence s_live;
		dec_valid && !nop_slot;
	endsequence
	sequence s_dead;
		dec_valid && nop_slot && !dest_acc && !dest_reg && !move_valid && !is_skip;
	endsequence

	// Result routing follows bit 9 of the word taken one edge earlier
	property p_dest;
		s_live ##0 alu_op == `OP_ADD |-> dest_reg == $past(instr_word[9]) && dest_acc != dest_reg;
	endproperty
	a_dest: assert property (p_dest) else $error("destination select wrong");
	property p_bank;
		s_live ##0 alu_op == `OP_ADD |-> reg_addr[7:0] == $past(instr_word[7:0])
			&& ($past(instr_word[8]) || reg_addr[11:8] == {4{reg_addr[7]}});
	endproperty
	a_bank: assert property (p_bank) else $error("register address wrong");
	property p_add_fl;
		s_live ##0 (alu_op == `OP_ADD || alu_op == `OP_ADDC) |-> flag_we == `FM_ALL;
	endproperty
	a_add_fl: assert property (p_add_fl) else $error("add flag mask wrong");
	property p_mul;
		prod_we |-> alu_op == `OP_MUL && flag_we == `FM_NONE && $past(instr_word[15:9]) == 7'h01;
	endproperty
	a_mul: assert property (p_mul) else $error("multiply decode wrong");
	property p_skip_fl;
		is_skip |-> flag_we == `FM_NONE;
	endproperty
	a_skip_fl: assert property (p_skip_fl) else $error("skip touches flags");
	// Squash of the slot behind an unconditional branch or a taken skip
	property p_bra_kill;
		rel_valid && !rel_is_cond && instr_valid |=> s_dead;
	endproperty
	a_bra_kill: assert property (p_bra_kill) else $error("branch follower not squashed");
	property p_skip_kill;
		is_skip && cond_true && instr_valid |=> s_dead;
	endproperty
	a_skip_kill: assert property (p_skip_kill) else $error("skipped word not squashed");
	// Side effects only ever aim at their own registers
	property p_pins;
		src_from_pins |-> reg_addr >= PORT_FIRST && reg_addr <= PORT_LAST;
	endproperty
	a_pins: assert property (p_pins) else $error("pin source off a port");
	property p_pclr;
		prescale_clr |-> reg_addr == TIMER_ZERO_ADDR;
	endproperty
	a_pclr: assert property (p_pclr) else $error("prescaler clear off timer");
endmodule

bind byte_op_instruction_decoder byte_op_decoder_checker #(
	.PORT_FIRST(PORT_FIRST), .PORT_LAST(PORT_LAST), .TIMER_ZERO_ADDR(TIMER_ZERO_ADDR)
) i_byte_op_decoder_checker (
	.ref_clk(ref_clk), .rst_n(rst_n), .instr_word(instr_word), .instr_valid(instr_valid),
	.cond_true(cond_true), .dec_valid(dec_valid), .nop_slot(nop_slot), .alu_op(alu_op),
	.flag_we(flag_we), .dest_acc(dest_acc), .dest_reg(dest_reg), .reg_addr(reg_addr),
	.is_skip(is_skip), .prod_we(prod_we), .src_from_pins(src_from_pins),
	.prescale_clr(prescale_clr), .move_valid(move_valid), .rel_valid(rel_valid),
	.rel_is_cond(rel_is_cond)
);

//--- verif/byte_op_instruction_decoder_tb_top.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`include "byte_op_consts.vh"

module byte_op_instruction_decoder_tb_top;
	typedef struct packed {
		logic        nop, dacc, dreg, skp, prd, pins, pclr, mv, jv, rv;
		logic [4:0]  alu, flg;
		logic [11:0] ra;
		logic [7:0]  lit;
		logic [2:0]  bs;
		logic [1:0]  exc;
		logic [23:0] aux;
	} rec_t;
	// Ports
	logic        ref_clk, rst_n, instr_valid, cond_true, take;
	logic [15:0] instr_word;
	logic [3:0]  bank_select_pointer, bsp;
	logic        dec_valid, nop_slot, dest_acc, dest_reg, is_skip, prod_we, src_from_pins;
	logic        prescale_clr, move_valid, jump_valid, is_call, fast_save, rel_valid, rel_is_cond;
	logic [4:0]  alu_op, flag_we;
	logic [11:0] reg_addr, move_src, move_dst, src, dst;
	logic [2:0]  bit_sel, rel_cond_code, b;
	logic [7:0]  literal, f;
	logic [1:0]  exec_cycles;
	logic [19:0] jump_target, rel_offset, t, tgt;
	// Bench state
	rec_t        e, m, dmask, o, me, mm;
	rec_t        q_e[$], q_m[$];
	int          num_errors, check_count, k;
	logic        d, a;
	// Pre-op {word[15:9], op, flags, has d, skip, fixed write}
	localparam logic [19:0] OPS [26] = '{
		{7'h12, `OP_ADD, `FM_ALL, 3'b100}, {7'h10, `OP_ADDC, `FM_ALL, 3'b100},
		{7'h0A, `OP_AND, `FM_ZN, 3'b100}, {7'h08, `OP_OR, `FM_ZN, 3'b100},
		{7'h0C, `OP_XOR, `FM_ZN, 3'b100}, {7'h0E, `OP_COM, `FM_ZN, 3'b100},
		{7'h2E, `OP_SUB_RA, `FM_ALL, 3'b100}, {7'h2C, `OP_SUBB_RA, `FM_ALL, 3'b100},
		{7'h2A, `OP_SUBB_AR, `FM_ALL, 3'b100}, {7'h16, `OP_DEC_SZ, `FM_NONE, 3'b110},
		{7'h26, `OP_DEC_SNZ, `FM_NONE, 3'b110}, {7'h1E, `OP_INC_SZ, `FM_NONE, 3'b110},
		{7'h24, `OP_INC_SNZ, `FM_NONE, 3'b110}, {7'h1A, `OP_RLC, `FM_CZN, 3'b100},
		{7'h18, `OP_RRC, `FM_CZN, 3'b100}, {7'h22, `OP_RL, `FM_ZN, 3'b100},
		{7'h20, `OP_RR, `FM_ZN, 3'b100}, {7'h30, `OP_CMP_LT, `FM_NONE, 3'b010},
		{7'h31, `OP_CMP_EQ, `FM_NONE, 3'b010}, {7'h32, `OP_CMP_GT, `FM_NONE, 3'b010},
		{7'h33, `OP_TEST_Z, `FM_NONE, 3'b010}, {7'h34, `OP_SET, `FM_NONE, 3'b001},
		{7'h35, `OP_CLR, `FM_Z, 3'b001}, {7'h36, `OP_NEG, `FM_ALL, 3'b001},
		{7'h37, `OP_STORE, `FM_NONE, 3'b001}, {7'h01, `OP_MUL, `FM_NONE, 3'b000}};
	localparam logic [3:0] BNIB [5] = '{4'h8, 4'h9, 4'h7, 4'hA, 4'hB};

	byte_op_instruction_decoder i_byte_op_instruction_decoder (
		.ref_clk(ref_clk), .rst_n(rst_n), .instr_word(instr_word), .instr_valid(instr_valid),
		.bank_select_pointer(bank_select_pointer), .cond_true(cond_true), .dec_valid(dec_valid),
		.nop_slot(nop_slot), .alu_op(alu_op), .flag_we(flag_we), .dest_acc(dest_acc),
		.dest_reg(dest_reg), .reg_addr(reg_addr), .bit_sel(bit_sel), .literal(literal),
		.is_skip(is_skip), .exec_cycles(exec_cycles), .prod_we(prod_we),
		.src_from_pins(src_from_pins), .prescale_clr(prescale_clr), .move_valid(move_valid),
		.move_src(move_src), .move_dst(move_dst), .jump_valid(jump_valid),
		.jump_target(jump_target), .is_call(is_call), .fast_save(fast_save),
		.rel_valid(rel_valid), .rel_is_cond(rel_is_cond), .rel_cond_code(rel_cond_code),
		.rel_offset(rel_offset));
	skip_datapath_model i_skip_datapath_model (
		.is_skip(is_skip), .rel_valid(rel_valid), .rel_is_cond(rel_is_cond), .take(take),
		.cond_true(cond_true));

	// Clock
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	task automatic check(input logic [68:0] got, input logic [68:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("Errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Present one word and note what it must decode to
	task automatic send(input logic [15:0] w);
		@(posedge ref_clk);
		instr_word          <= w;
		instr_valid         <= 1'b1;
		bank_select_pointer <= bsp;
		q_e.push_back(e);
		q_m.push_back(m);
	endtask

	// Idle cycles carry junk words that must be ignored
	task automatic gap(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			instr_valid <= 1'b0;
			instr_word  <= 16'($urandom);
		end
	endtask

	task automatic dead(input logic [15:0] w);
		e     = '0;
		e.nop = 1'b1;
		m     = dmask;
		send(w);
	endtask

	// File-register expectation from a table entry and current d, a, f, bank
	task automatic fill(input logic [19:0] tt);
		e      = '0;
		m      = dmask;
		m.ra   = '1;
		m.lit  = '1;
		m.exc  = '1;
		e.alu  = tt[12:8];
		e.flg  = tt[7:3];
		e.dacc = tt[2] & ~d;
		e.dreg = (tt[2] & d) | tt[0];
		e.skp  = tt[1];
		e.prd  = tt[12:8] == `OP_MUL;
		e.ra   = a ? {bsp, f} : {{4{f[7]}}, f};
		e.lit  = f;
		e.exc  = 2'h1;
	endtask

	// Monitor: each decoded slot is matched against the oldest note
	always @(posedge ref_clk) begin
		if (dec_valid === 1'b1) begin
			o = {nop_slot, dest_acc, dest_reg, is_skip, prod_we, src_from_pins, prescale_clr,
				move_valid, jump_valid, rel_valid, alu_op, flag_we, reg_addr, literal, bit_sel,
				exec_cycles, 24'h0};
			o.aux = move_valid ? {move_src, move_dst} : jump_valid ? {is_call, fast_save, 2'h0,
				jump_target} : rel_valid ? {rel_is_cond, rel_cond_code, rel_offset} : 24'h0;
			if (q_e.size() == 0) begin
				check(69'h1, 69'h0);
			end else begin
				mm = q_m.pop_front();
				me = q_e.pop_front();
				check(o & mm, me & mm);
			end
		end
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		close_out();
	end

	initial begin
		k = $urandom(32'h116b);
		{rst_n, instr_valid, take, instr_word, bank_select_pointer, bsp} = '0;
		num_errors = 0;
		check_count = 0;
		dmask = '1;
		{dmask.ra, dmask.lit, dmask.bs, dmask.exc, dmask.pins, dmask.pclr} = '0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Each of the 26 table codes three times (no DEC, INC, MOVF or SWAP), random fields, bank and bubbles
		for (k = 0; k < 78; k++) begin
			{d, a, f, bsp} = 14'($urandom);
			t = OPS[k % 26];
			fill(t);
			send({t[19:14], t[2] ? d : t[13], a, f});
			gap($urandom_range(1, 0));
		end
		// Port read-modify-write, then a clear of the timer count
		{d, a, f} = 10'h280;
		fill(OPS[0]);
		{m.pins, e.pins} = 2'h3;
		send(16'h2680);
		f = 8'hD6;
		fill(OPS[22]);
		{m.pclr, e.pclr} = 2'h3;
		send(16'h6AD6);
		// Bit set, clear, toggle and both bit tests
		for (k = 0; k < 10; k++) begin
			{a, f, bsp, b} = 16'($urandom);
			fill({7'h0, `OP_BIT, `FM_NONE, 1'b0, k % 5 > 2, k % 5 < 3});
			e.bs = b;
			m.bs = '1;
			send({BNIB[k % 5], b, a, f});
		end
		// Unconditional branch; its follower is squashed (awkward: back to back)
		t = 20'($urandom);
		e = '0;
		m = dmask;
		{e.rv, e.exc, m.exc} = 5'h1B;
		e.aux = {1'b0, t[10:8], {9{t[10]}}, t[10:0]};
		send({5'h1A, t[10:0]});
		dead(16'h2601);
		// All eight conditional branch codes
		for (k = 0; k < 8; k++) begin
			f = 8'($urandom);
			e = '0;
			m = dmask;
			e.rv = 1'b1;
			e.aux = {1'b1, 3'(k), {12{f[7]}}, f};
			send({5'h1C, 3'(k), f});
		end
		// Two-word move, goto, call without and with context save
		{src, dst} = 24'($urandom);
		e = '0;
		m = dmask;
		{e.exc, m.exc} = 4'hB;
		send({4'hC, src});
		{e.exc, m.exc, e.mv} = 5'h01;
		e.aux = {src, dst};
		send({4'hF, dst});
		for (k = 0; k < 3; k++) begin
			tgt = 20'($urandom);
			e = '0;
			m = dmask;
			{e.exc, m.exc} = 4'hB;
			send(k == 0 ? {8'hEF, tgt[7:0]} : {7'h76, k[1], tgt[7:0]});
			{e.exc, m.exc, e.jv} = 5'h01;
			e.aux = {k != 0, k == 2, 2'h0, tgt};
			send({4'hF, tgt[19:8]});
		end
		// Lone second word, a no-op code and a literal load
		dead(16'hF123);
		e = '0;
		m = dmask;
		send(16'h0000);
		m = '0;
		{m.alu, m.lit, e.lit} = 18'h3FF55;
		send(16'h0E55);
		gap(2);
		// Taken skips: follower, follower after a bubble, a whole two-word move
		take <= 1'b1;
		for (k = 0; k < 3; k++) begin
			{d, a, f, bsp} = 14'($urandom);
			fill(OPS[18]);
			send({7'h31, a, f});
			gap(k == 1);
			dead(k == 2 ? 16'hC123 : 16'h2601);
			if (k == 2) begin
				dead(16'hF456);
			end
			gap(1);
		end
		take <= 1'b0;
		gap(3);
		for (k = 0; k < 20 && q_e.size() != 0; k++) begin
			@(posedge ref_clk);
		end
		if (q_e.size() != 0) begin
			num_errors++;
		end
		close_out();
	end
endmodule
